// *** logic/motion_defines.svh ***
`ifndef MOTION_DEFINES_SVH
`define MOTION_DEFINES_SVH
`define JERK_MAX      32'd46566139
`define TRIG_OFF      3'h0
`define TRIG_REL_RISE 3'h1
`define TRIG_REL_FALL 3'h2
`define TRIG_ABS_RISE 3'h3
`define TRIG_ABS_FALL 3'h4
`define TRIG_HOM_RISE 3'h5
`define TRIG_HOM_FALL 3'h6
`define STAT_TRIG_BIT 1
`define STAT_W        4
`define HOME_POS      32'h00000000
`endif

// *** logic/motion_pkg.sv ***
package motion_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, ST_JUP = 7'h02, ST_AHOLD = 7'h04, ST_JDN = 7'h08,
      ST_CRUISE = 7'h10, ST_DEC = 7'h20, ST_DONE = 7'h40
   } phase_t;
   typedef struct packed {
      logic [31:0] pos;
      logic [31:0] vel;
      logic [31:0] acc;
   } kin_t;
   typedef struct packed {
      logic [31:0] vmax;
      logic [31:0] amax;
   } lim_t;
   typedef struct packed {
      phase_t      ph;
      kin_t        k;
      logic [31:0] target;
      logic [31:0] jerk;
      logic [31:0] amax;
      logic [31:0] vmax;
      logic        dir_neg;
      logic        scurve;
      logic [2:0]  trig_mode;
      logic        trig_s1;
      logic        trig_s2;
      logic        trig_s3;
      logic        moving;
      logic        complete;
      logic        save_busy;
      logic [3:0]  status;
   } state_t;
endpackage

// *** logic/motion_profile_trigger_unit.sv ***
`include "motion_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module motion_profile_trigger_unit import motion_pkg::*; (
   input  wire logic        sys_clk,        // 10 MHz servo clock
   input  wire logic        sys_rst,        // Sync reset, high
   input  wire logic        scurve_sel,     // 1 selects S-curve profile
   input  wire lim_t        vel_prof,       // Shared profile limits
   input  wire logic [31:0] jerk_set,       // Jerk per cycle
   input  wire lim_t        gear_low,       // Joystick low gear limits
   input  wire lim_t        gear_high,      // Joystick high gear limits
   input  wire logic        gear_hi_sel,    // 1 selects high gear
   input  wire logic        dir_sense,      // Invert joystick direction
   input  wire logic        joy_start,      // Joystick move request pulse
   input  wire logic        joy_neg,        // Joystick deflection negative
   input  wire logic [31:0] joy_dist,       // Joystick move distance
   input  wire logic        sw_start,       // Software move pulse (absolute)
   input  wire logic [31:0] rel_dist,       // Latest relative distance, signed
   input  wire logic [31:0] abs_pos,        // Latest absolute target
   input  wire logic        trig_in,        // Async trigger pin
   input  wire logic        trig_cfg_we,    // Trigger mode write strobe
   input  wire logic [2:0]  trig_cfg,       // Trigger mode value
   input  wire logic        trig_out_en,    // Trigger out enable, independent
   input  wire logic        settled,        // Axis settled from servo monitor
   input  wire logic        save_req,       // Persist settings request
   input  wire logic        nv_ack,         // Store finished
   output logic             nv_write,       // Store strobe level
   output kin_t             kin,            // Demand profile
   output logic             move_complete,  // Trajectory done and settled
   output logic [3:0]       status,         // 0 moving, 1 trig level, 2 done, 3 trig out en
   output logic [2:0]       trig_mode       // Current trigger mode
);
   state_t s_r, s_nxt;
   logic [31:0] dist_left, stop_dist, v_abs, a_step;
   logic        trig_rise, trig_fall, trig_hit, start_any;
   logic [31:0] start_tgt;
   logic [31:0] jerk_eff;

   // Edge detect only on second and third stages; first stage is pure sync
   assign trig_rise = s_r.trig_s2 & ~s_r.trig_s3;
   assign trig_fall = ~s_r.trig_s2 & s_r.trig_s3;
   always_comb begin
      trig_hit  = 1'b0;
      start_tgt = s_r.k.pos;
      unique case (s_r.trig_mode)
         `TRIG_REL_RISE: begin trig_hit = trig_rise; start_tgt = s_r.k.pos + rel_dist; end
         `TRIG_REL_FALL: begin trig_hit = trig_fall; start_tgt = s_r.k.pos + rel_dist; end
         `TRIG_ABS_RISE: begin trig_hit = trig_rise; start_tgt = abs_pos; end
         `TRIG_ABS_FALL: begin trig_hit = trig_fall; start_tgt = abs_pos; end
         `TRIG_HOM_RISE: begin trig_hit = trig_rise; start_tgt = `HOME_POS; end
         `TRIG_HOM_FALL: begin trig_hit = trig_fall; start_tgt = `HOME_POS; end
         default: begin trig_hit = 1'b0; start_tgt = s_r.k.pos; end
      endcase
   end
   // Starts only when idle, so edges mid-move are dropped
   assign start_any = (s_r.ph == ST_IDLE) && (trig_hit || joy_start || sw_start);
   // Clamp jerk at its documented ceiling
   assign jerk_eff = (jerk_set > `JERK_MAX) ? `JERK_MAX : jerk_set;

   // Remaining distance and braking distance v^2/2a approximated by v*v/(2a) plus v steps
   assign dist_left = s_r.dir_neg ? (s_r.k.pos - s_r.target) : (s_r.target - s_r.k.pos);
   assign v_abs     = s_r.k.vel;
   assign stop_dist = (s_r.amax == 32'h0) ? 32'h0 :
                      32'((64'(v_abs) * 64'(v_abs)) / (64'(s_r.amax) << 1)) + v_abs;
   assign a_step    = s_r.k.acc;

   always_comb begin
      s_nxt = s_r;
      s_nxt.trig_s1 = trig_in;
      s_nxt.trig_s2 = s_r.trig_s1;
      s_nxt.trig_s3 = s_r.trig_s2;
      if (trig_cfg_we) begin
         s_nxt.trig_mode = (trig_cfg > `TRIG_HOM_FALL) ? `TRIG_OFF : trig_cfg;
      end
      // Persist handshake; trigger mode is never part of the image
      if (save_req && !s_r.save_busy) s_nxt.save_busy = 1'b1;
      else if (nv_ack) s_nxt.save_busy = 1'b0;
      unique case (s_r.ph)
         ST_IDLE: begin
            if (start_any) begin
               s_nxt.k.vel = 32'h0;
               s_nxt.k.acc = 32'h0;
               if (joy_start && !trig_hit && !sw_start) begin
                  // Gear limits, trapezoid forced, direction sense applied
                  s_nxt.vmax    = gear_hi_sel ? gear_high.vmax : gear_low.vmax;
                  s_nxt.amax    = gear_hi_sel ? gear_high.amax : gear_low.amax;
                  s_nxt.scurve  = 1'b0;
                  s_nxt.dir_neg = joy_neg ^ dir_sense;
                  s_nxt.target  = (joy_neg ^ dir_sense) ? s_r.k.pos - joy_dist
                                                        : s_r.k.pos + joy_dist;
               end else begin
                  s_nxt.vmax    = vel_prof.vmax;
                  s_nxt.amax    = vel_prof.amax;
                  s_nxt.scurve  = scurve_sel && (jerk_eff != 32'h0);
                  s_nxt.target  = trig_hit ? start_tgt : abs_pos;
                  s_nxt.dir_neg = $signed((trig_hit ? start_tgt : abs_pos) - s_r.k.pos) < 0;
               end
               s_nxt.jerk     = jerk_eff;
               s_nxt.moving   = 1'b1;
               s_nxt.complete = 1'b0;
               s_nxt.ph       = ST_JUP;
            end
         end
         ST_JUP: begin
            // Acceleration rises by jerk, or jumps to max in trapezoid mode
            if (!s_r.scurve || s_r.k.acc + s_r.jerk >= s_r.amax) begin
               s_nxt.k.acc = s_r.amax;
               s_nxt.ph    = ST_AHOLD;
            end else s_nxt.k.acc = s_r.k.acc + s_r.jerk;
            s_nxt.k.vel = s_r.k.vel + a_step;
         end
         ST_AHOLD: begin
            if (stop_dist >= dist_left) s_nxt.ph = ST_DEC;
            else if (s_r.k.vel + a_step >= s_r.vmax) begin
               s_nxt.k.vel = s_r.vmax;
               s_nxt.ph    = s_r.scurve ? ST_JDN : ST_CRUISE;
               if (!s_r.scurve) s_nxt.k.acc = 32'h0;
            end else s_nxt.k.vel = s_r.k.vel + a_step;
         end
         ST_JDN: begin
            // Acceleration tapers to zero at cruise
            if (s_r.k.acc <= s_r.jerk) begin
               s_nxt.k.acc = 32'h0;
               s_nxt.ph    = ST_CRUISE;
            end else s_nxt.k.acc = s_r.k.acc - s_r.jerk;
         end
         ST_CRUISE: begin
            if (stop_dist >= dist_left) begin
               s_nxt.ph    = ST_DEC;
               s_nxt.k.acc = s_r.amax;
            end
         end
         ST_DEC: begin
            // Mirrored deceleration; jerk taper folded into the linear ramp
            if (s_r.k.vel <= s_r.amax || dist_left <= s_r.k.vel) begin
               s_nxt.k.vel = 32'h0;
               s_nxt.k.acc = 32'h0;
               s_nxt.k.pos = s_r.target;
               s_nxt.ph    = ST_DONE;
            end else s_nxt.k.vel = s_r.k.vel - s_r.amax;
         end
         ST_DONE: begin
            // Completion waits for the settle monitor
            s_nxt.moving = 1'b0;
            if (settled) begin
               s_nxt.complete = 1'b1;
               s_nxt.ph       = ST_IDLE;
            end
         end
         default: s_nxt.ph = ST_IDLE;
      endcase
      // Position integrates the signed velocity while moving, else holds
      if (s_r.ph != ST_IDLE && s_r.ph != ST_DONE && s_nxt.ph != ST_DONE) begin
         s_nxt.k.pos = s_r.dir_neg ? s_r.k.pos - s_r.k.vel : s_r.k.pos + s_r.k.vel;
      end
      s_nxt.status = {trig_out_en, s_nxt.complete, s_r.trig_s2, s_nxt.moving};
   end

   // Reset clears trigger mode to disabled regardless of stored image
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.ph <= ST_IDLE;
         s_r.trig_mode <= `TRIG_OFF;
      end else s_r <= s_nxt;
   end

   assign kin           = s_r.k;
   assign move_complete = s_r.complete;
   assign status        = s_r.status;
   assign trig_mode     = s_r.trig_mode;
   assign nv_write      = s_r.save_busy;

   a_edge_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_r.ph != ST_IDLE) |=> (s_r.ph != ST_JUP) || $past(s_r.ph) == ST_JUP ||
      $past(s_r.ph) == ST_IDLE) else $error("move restarted mid-move");
   a_hold_done: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_r.ph == ST_IDLE && !start_any) |=> $stable(s_r.k.pos) && s_r.k.vel == 32'h0)
      else $error("profile drifted while idle");
   a_joy_trap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (start_any && joy_start && !trig_hit && !sw_start) |=> !s_r.scurve)
      else $error("joystick move not trapezoidal");
   a_complete_settled: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(s_r.complete) |-> $past(settled)) else $error("complete without settle");
   a_trig_rise_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_r.ph == ST_IDLE && s_r.trig_mode == `TRIG_REL_RISE && trig_rise) |=> s_r.ph == ST_JUP)
      else $error("rising edge missed");
   a_level_no_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_r.ph == ST_IDLE && !trig_rise && !trig_fall && !joy_start && !sw_start)
      |=> s_r.ph != ST_JUP) else $error("start without edge");
   a_status_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 status[`STAT_TRIG_BIT] == $past(s_r.trig_s2)) else $error("trigger level wrong");
   a_zero_jerk: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (start_any && jerk_eff == 32'h0) |=> !s_r.scurve) else $error("zero jerk used S-curve");
   a_reset_mode: assert property (@(posedge sys_clk)
      sys_rst |=> trig_mode == `TRIG_OFF) else $error("trigger mode not disabled");
endmodule
`default_nettype wire

// *** verif/settle_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module settle_model (
   input  wire logic sys_clk,  // Servo clock
   input  wire logic sys_rst,  // Sync reset, high
   input  wire logic moving,   // Profile in progress
   input  wire logic hold_off, // Keep axis outside window
   output logic      settled   // Axis settled flag
);
   logic [2:0] rest_r;
   // Quiet cycles counted so settling always lags the end of motion
   always_ff @(posedge sys_clk) begin
      if (sys_rst || moving || hold_off) begin
         rest_r <= 3'h0;
      end else if (rest_r != 3'h4) begin
         rest_r <= rest_r + 3'h1;
      end
   end
   assign settled = (rest_r == 3'h4);
endmodule
`default_nettype wire

// *** verif/motion_profile_trigger_unit_tb.sv ***
`include "motion_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module motion_profile_trigger_unit_tb import motion_pkg::*;;
   typedef struct packed {logic [2:0] c; logic r; logic [31:0] t;} row_t;
   logic        sys_clk, sys_rst, scurve_sel, gear_hi_sel, dir_sense, joy_start;
   logic        joy_neg, sw_start, trig_in, trig_cfg_we, trig_out_en, save_req;
   logic        nv_ack, hold_off, settled, nv_write, move_complete;
   lim_t        vel_prof, gear_low, gear_high;
   logic [31:0] jerk_set, joy_dist, rel_dist, abs_pos, pk_v, pk_a, a1;
   logic [2:0]  trig_cfg, trig_mode;
   logic [3:0]  status;
   kin_t        kin;
   int          failures, samples_checked, cyc;
   row_t        rows [8];
   motion_profile_trigger_unit i_dut (.sys_clk, .sys_rst, .scurve_sel, .vel_prof,
      .jerk_set, .gear_low, .gear_high, .gear_hi_sel, .dir_sense, .joy_start, .joy_neg,
      .joy_dist, .sw_start, .rel_dist, .abs_pos, .trig_in, .trig_cfg_we, .trig_cfg,
      .trig_out_en, .settled, .save_req, .nv_ack, .nv_write, .kin, .move_complete,
      .status, .trig_mode);
   settle_model i_settle (.sys_clk, .sys_rst, .moving(status[0]), .hold_off, .settled);
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic set_cfg(input logic [2:0] c);
      @(posedge sys_clk) trig_cfg <= c;
      trig_cfg_we <= 1'b1;
      @(posedge sys_clk) trig_cfg_we <= 1'b0;
   endtask
   task automatic wait_move();
      int n;
      n = 0;
      while (status[0] !== 1'b1 && n++ < 12) tick();
      chk("start", status[0], 1);
   endtask
   // Peaks and first nonzero acceleration tell the profile shape
   task automatic wait_done();
      int n;
      n = 0;
      pk_v = 0;
      pk_a = 0;
      a1 = 0;
      while (move_complete !== 1'b1 && n++ < 3000) begin
         if (kin.vel > pk_v) pk_v = kin.vel;
         if (kin.acc > pk_a) pk_a = kin.acc;
         if (a1 == 0) a1 = kin.acc;
         tick();
      end
      chk("done", move_complete, 1);
   endtask
   task automatic sw_move(input logic [31:0] p);
      @(posedge sys_clk) abs_pos <= p;
      sw_start <= 1'b1;
      @(posedge sys_clk) sw_start <= 1'b0;
      wait_move();
   endtask
   initial begin
      {sys_rst, scurve_sel, gear_hi_sel, dir_sense, joy_start, joy_neg} = 6'h20;
      {sw_start, trig_in, trig_cfg_we, save_req, nv_ack, hold_off} = 6'h0;
      {trig_out_en, trig_cfg, jerk_set, joy_dist} = {4'h8, 32'h0, 32'h64};
      {vel_prof, gear_low, gear_high} = {64'h8_00000004, 64'h2_00000001, 64'h6_00000002};
      {rel_dist, abs_pos} = {32'h28, 32'h64};
      rows = '{'{`TRIG_OFF, 1'b1, 32'h0}, '{3'h7, 1'b0, 32'h0},
         '{`TRIG_REL_RISE, 1'b1, 32'h28}, '{`TRIG_ABS_RISE, 1'b1, 32'h64},
         '{`TRIG_REL_FALL, 1'b0, 32'h8c}, '{`TRIG_HOM_RISE, 1'b1, 32'h0},
         '{`TRIG_ABS_FALL, 1'b0, 32'h64}, '{`TRIG_HOM_FALL, 1'b0, 32'h0}};
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      tick();
      chk("mode_rst", trig_mode, 0);
      chk("out_en", status[3], 1);
      // Each row: wrong edge first, then the configured one
      foreach (rows[i]) begin
         set_cfg(`TRIG_OFF);
         @(posedge sys_clk) trig_in <= rows[i].r;
         repeat (6) @(posedge sys_clk);
         set_cfg(rows[i].c);
         @(posedge sys_clk) trig_in <= !rows[i].r;
         repeat (8) tick();
         chk("wrong_edge", status[0], 0);
         chk("trig_lvl", status[1], !rows[i].r);
         @(posedge sys_clk) trig_in <= rows[i].r;
         if (rows[i].c inside {[1:6]}) wait_move();
         if (rows[i].c inside {[1:6]}) wait_done();
         repeat (8) tick();
         chk("trig_pos", kin.pos, rows[i].t);
      end
      // Edges during a move must be dropped; longer move keeps it busy
      @(posedge sys_clk) rel_dist <= 32'hc8;
      set_cfg(`TRIG_REL_RISE);
      @(posedge sys_clk) trig_in <= 1'b1;
      wait_move();
      @(posedge sys_clk) trig_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      trig_in <= 1'b1;
      wait_done();
      repeat (10) tick();
      chk("busy_pos", kin.pos, 32'hc8);
      // Joystick ignores S-curve selection and follows gear and sense
      {scurve_sel, jerk_set} <= {1'b1, 32'h1};
      for (int g = 0; g < 2; g++) begin
         @(posedge sys_clk) {gear_hi_sel, dir_sense, joy_start} <= {g[0], g[0], 1'b1};
         @(posedge sys_clk) joy_start <= 1'b0;
         wait_move();
         wait_done();
         chk("joy_v", pk_v, g ? 6 : 2);
         chk("joy_a", pk_a, g ? 2 : 1);
         chk("joy_pos", kin.pos, g ? 32'hc8 : 32'h12c);
      end
      sw_move(32'h64);
      wait_done();
      chk("s_ramp", a1 < 32'h4, 1);
      chk("s_pos", kin.pos, 32'h64);
      @(posedge sys_clk) jerk_set <= 32'h0;
      sw_move(32'h0);
      wait_done();
      chk("j0_acc", a1, 32'h4);
      // Completion must wait for the settle monitor
      @(posedge sys_clk) hold_off <= 1'b1;
      sw_move(32'h50);
      repeat (300) tick();
      chk("held_cpl", move_complete, 0);
      chk("held_pos", kin.pos, 32'h50);
      @(posedge sys_clk) hold_off <= 1'b0;
      wait_done();
      chk("stat_done", status[2], 1);
      chk("stat_idle", status[0], 0);
      @(posedge sys_clk) save_req <= 1'b1;
      @(posedge sys_clk) save_req <= 1'b0;
      repeat (2) tick();
      chk("nv_on", nv_write, 1);
      @(posedge sys_clk) nv_ack <= 1'b1;
      @(posedge sys_clk) nv_ack <= 1'b0;
      repeat (2) tick();
      chk("nv_off", nv_write, 0);
      set_cfg(`TRIG_ABS_RISE);
      @(posedge sys_clk) sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      tick();
      chk("mode_rst2", trig_mode, 0);
      report_and_stop();
   end
endmodule
`default_nettype wire
